/* File: hw/dps_consts.vh */
// constants for the dual synthesizer digital core
`ifndef DPS_CONSTS_VH
`define DPS_CONSTS_VH

// ****************************************************************
// serial word layout
// ****************************************************************
`define DPS_WORD_BITS      48
`define DPS_TX_RATIO_LSB   0
`define DPS_RX_RATIO_LSB   16
`define DPS_REF_SEL_LSB    32
`define DPS_THR_SEL_LSB    37
`define DPS_HOLD_SEL_BIT   40
`define DPS_DZ_LO_BIT      41
`define DPS_DZ_HI_BIT      42
`define DPS_TX_FL_EN_BIT   43
`define DPS_RX_FL_EN_BIT   44
`define DPS_FL_POLICY_BIT  45
`define DPS_TEST_A_BIT     46
`define DPS_TEST_B_BIT     47

// ****************************************************************
// reference divider codes and ratios
// ****************************************************************
`define DPS_REF_CODE_A     5'h00
`define DPS_REF_CODE_B     5'h1F
`define DPS_REF_CODE_C     5'h07
`define DPS_REF_RATIO_A    12'h800
`define DPS_REF_RATIO_B    12'h6A4
`define DPS_REF_RATIO_C    12'hD48

// ****************************************************************
// timing
// ****************************************************************
`define DPS_CLK_MHZ        125
`define DPS_THR1_NS        150
`define DPS_THR2_NS        300
`define DPS_THR4_NS        1250
`define DPS_THR6_NS        5000
`define DPS_HOLD_SHORT_US  2500
`define DPS_HOLD_LONG_US   5000
`define DPS_DZ_NARROW_CYC  10'h001
`define DPS_DZ_MEDIUM_CYC  10'h002
`define DPS_DZ_WIDE_CYC    10'h004

`endif

/* File: hw/dps_serial_rx.v */
// three-wire serial receiver that assembles the configuration word
`timescale 1ns/1ps
`default_nettype none
`include "dps_consts.vh"

module dps_serial_rx (
   input  wire        clk,             // system clock
   input  wire        arst_n,          // async reset, active low
   input  wire        serial_in_line,  // serial data pin
   input  wire        serial_shift_strobe, // shift clock pin
   input  wire        serial_enable,   // frame enable pin
   output reg  [47:0] word_q,          // last complete word
   output reg         word_stb_q       // one-cycle pulse on new word
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   reg  [2:0]  s1_q;
   reg  [2:0]  s2_q;
   reg  [2:1]  s3_q;
   reg  [47:0] shift_q;
   reg  [5:0]  cnt_q;
   wire        strobe_rise;
   wire        enable_fall;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 2'h0;
      end else begin
         s1_q <= {serial_enable, serial_shift_strobe, serial_in_line};
         s2_q <= s1_q;
         s3_q <= s2_q[2:1];
      end
   end

   assign strobe_rise = s2_q[1] & ~s3_q[1];
   assign enable_fall = ~s2_q[2] & s3_q[2];

   // ****************************************************************
   // shift and latch
   // ****************************************************************
   // first bit ends up in bit 0; a frame of any other length is dropped
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_q    <= 48'h0;
         cnt_q      <= 6'h00;
         word_q     <= 48'h0;
         word_stb_q <= 1'b0;
      end else begin
         word_stb_q <= 1'b0;
         if (enable_fall) begin
            cnt_q <= 6'h00;
            if (cnt_q == 6'h30) begin // RULE_19
               word_q     <= shift_q;
               word_stb_q <= 1'b1;
            end
         end else if (s2_q[2] && strobe_rise) begin
            shift_q <= {s2_q[0], shift_q[47:1]}; // RULE_19
            if (cnt_q != 6'h31)
               cnt_q <= cnt_q + 6'h01;
         end
      end
   end

endmodule
`default_nettype wire

/* File: hw/dps_core.v */
// dual synthesizer digital core: dividers, phase detectors, unlock and fast-lock control
`timescale 1ns/1ps
`default_nettype none
`include "dps_consts.vh"

// Behaviour
// [RULE_01] reference divided by 2048, 1700 or 3400 chosen by five-bit select code
// [RULE_02] sixteen-bit transmit and receive ratios, bit zero least significant
// [RULE_03] host keeps each ratio between 256 and 65535
// [RULE_04] each oscillator input divided by twice its programmed ratio
// [RULE_05] main pump drives high when divided input leads, low when lagging
// [RULE_06] main pump floats when divided input and reference coincide
// [RULE_07] unlocked loop pulls unlock output low, aux pump copies main pump
// [RULE_08] unlock asserted when phase error exceeds the selected threshold
// [RULE_09] three-bit code selects threshold 0, 0.15, 0.3, 1.25 or 5 us
// [RULE_10] unlock extended 2.5 ms when hold select is 0, 5 ms when 1
// [RULE_11] no extension when threshold code is all zeros
// [RULE_12] two-bit code picks narrow, medium or wide dead band; 00 illegal
// [RULE_13] fast-lock enabled per loop by its enable bit
// [RULE_14] policy bit 1 runs fast-lock always, 0 only while unlocked
// [RULE_15] host writes zero to both factory test bits
// [RULE_16] aux pump active while unlocked, floats once the loop locks
// [RULE_17] host uses small threshold while switching, large one once locked
// [RULE_18] unlock output released when locked and extension expired
// [RULE_19] 48-bit word, transmit ratio bit zero first, captured in that order
// [RULE_20] host holds each serial timing interval over 32 reference periods
// [RULE_21] outputs undefined until the first complete word is programmed
module dps_core #(
   parameter HOLD_SHORT_CYC = `DPS_HOLD_SHORT_US * `DPS_CLK_MHZ, // short unlock extension
   parameter HOLD_LONG_CYC  = `DPS_HOLD_LONG_US * `DPS_CLK_MHZ   // long unlock extension
) (
   input  wire clk,                  // system clock, 125 MHz
   input  wire arst_n,               // async reset, active low
   input  wire ref_osc_in,           // reference oscillator pin
   input  wire tx_lo_in,             // transmit oscillator pin
   input  wire rx_lo_in,             // receive oscillator pin
   input  wire serial_in_line,       // serial data pin
   input  wire serial_shift_strobe,  // serial shift clock pin
   input  wire serial_enable,        // serial frame enable pin
   output wire tx_pump_main_out,     // transmit main pump level
   output wire tx_pump_main_oe,      // transmit main pump drive enable
   output wire rx_pump_main_out,     // receive main pump level
   output wire rx_pump_main_oe,      // receive main pump drive enable
   output wire tx_pump_aux_out,      // transmit aux pump level
   output wire tx_pump_aux_oe,       // transmit aux pump drive enable
   output wire rx_pump_aux_out,      // receive aux pump level
   output wire rx_pump_aux_oe,       // receive aux pump drive enable
   output wire tx_unlock_n,          // transmit unlock open-drain level
   output wire tx_unlock_oe,         // transmit unlock pull-down enable
   output wire rx_unlock_n,          // receive unlock open-drain level
   output wire rx_unlock_oe,         // receive unlock pull-down enable
   output wire tx_fast_lock_on,      // transmit fast-lock switch
   output wire rx_fast_lock_on,      // receive fast-lock switch
   output wire factory_test_bit_a,   // stored test bit a
   output wire factory_test_bit_b,   // stored test bit b
   output wire cfg_loaded            // a complete word has been taken
);

   // ****************************************************************
   // configuration word
   // ****************************************************************
   wire [47:0] rx_word;
   wire        rx_word_stb;
   reg  [47:0] cfg_q;
   reg         cfg_valid_q;

   dps_serial_rx u_serial (
      .clk                 (clk),
      .arst_n              (arst_n),
      .serial_in_line      (serial_in_line),
      .serial_shift_strobe (serial_shift_strobe),
      .serial_enable       (serial_enable),
      .word_q              (rx_word),
      .word_stb_q          (rx_word_stb)
   );

   // outputs stay released until the first full word arrives
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q       <= 48'h0;
         cfg_valid_q <= 1'b0;
      end else if (rx_word_stb) begin
         cfg_q       <= rx_word;
         cfg_valid_q <= 1'b1; // RULE_21
      end
   end

   wire [15:0] tx_ratio_bits        = cfg_q[`DPS_TX_RATIO_LSB +: 16]; // RULE_02
   wire [15:0] rx_ratio_bits        = cfg_q[`DPS_RX_RATIO_LSB +: 16]; // RULE_02
   wire [4:0]  ref_ratio_sel        = cfg_q[`DPS_REF_SEL_LSB +: 5];
   wire [2:0]  unlock_threshold_sel = cfg_q[`DPS_THR_SEL_LSB +: 3];
   wire        unlock_hold_sel      = cfg_q[`DPS_HOLD_SEL_BIT];
   wire [1:0]  deadband_sel         = {cfg_q[`DPS_DZ_HI_BIT], cfg_q[`DPS_DZ_LO_BIT]};
   wire        fast_lock_policy     = cfg_q[`DPS_FL_POLICY_BIT];
   wire [1:0]  fast_lock_en         = {cfg_q[`DPS_RX_FL_EN_BIT], cfg_q[`DPS_TX_FL_EN_BIT]};

   // ****************************************************************
   // threshold, dead band and extension decode
   // ****************************************************************
   reg [9:0]  thr_cyc;
   reg [9:0]  dz_cyc;
   reg [19:0] hold_len;

   // whole clk cycles, rounded down at 125 MHz
   localparam THR1_CYC = `DPS_THR1_NS * `DPS_CLK_MHZ / 1000;
   localparam THR2_CYC = `DPS_THR2_NS * `DPS_CLK_MHZ / 1000;
   localparam THR4_CYC = `DPS_THR4_NS * `DPS_CLK_MHZ / 1000;
   localparam THR6_CYC = `DPS_THR6_NS * `DPS_CLK_MHZ / 1000;

   always @* begin
      case (unlock_threshold_sel) // RULE_09
         3'h0:    thr_cyc = 10'h000;
         3'h1:    thr_cyc = THR1_CYC[9:0];
         3'h2:    thr_cyc = THR2_CYC[9:0];
         3'h3:    thr_cyc = THR2_CYC[9:0]; // illegal code, treated as 010
         3'h4,
         3'h5:    thr_cyc = THR4_CYC[9:0];
         default: thr_cyc = THR6_CYC[9:0];
      endcase
      case (deadband_sel) // RULE_12
         2'h2:    dz_cyc = `DPS_DZ_MEDIUM_CYC;
         2'h3:    dz_cyc = `DPS_DZ_WIDE_CYC;
         default: dz_cyc = `DPS_DZ_NARROW_CYC; // illegal 00 falls back to narrow
      endcase
      if (unlock_threshold_sel == 3'h0)
         hold_len = 20'h00001; // RULE_11
      else if (unlock_hold_sel)
         hold_len = HOLD_LONG_CYC[19:0]; // RULE_10
      else
         hold_len = HOLD_SHORT_CYC[19:0]; // RULE_10
   end

   // ****************************************************************
   // reference divider
   // ****************************************************************
   reg  [2:0]  ref_sync_q;
   reg  [11:0] ref_cnt_q;
   reg  [11:0] ref_ratio;
   reg         ref_tick_q;
   wire        ref_edge = ref_sync_q[1] & ~ref_sync_q[2];

   always @* begin
      case (ref_ratio_sel) // RULE_01
         `DPS_REF_CODE_B: ref_ratio = `DPS_REF_RATIO_B;
         `DPS_REF_CODE_C: ref_ratio = `DPS_REF_RATIO_C;
         default:         ref_ratio = `DPS_REF_RATIO_A; // unlisted codes use the 2048 ratio
      endcase
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ref_sync_q <= 3'h0;
         ref_cnt_q  <= 12'h000;
         ref_tick_q <= 1'b0;
      end else begin
         ref_sync_q <= {ref_sync_q[1:0], ref_osc_in};
         ref_tick_q <= 1'b0;
         if (ref_edge) begin
            if (ref_cnt_q >= ref_ratio - 12'h001) begin // RULE_01
               ref_cnt_q  <= 12'h000;
               ref_tick_q <= cfg_valid_q;
            end else begin
               ref_cnt_q <= ref_cnt_q + 12'h001;
            end
         end
      end
   end

   // ****************************************************************
   // per-loop divider, phase detector, unlock and fast-lock
   // ****************************************************************
   wire [1:0]  lo_pin = {rx_lo_in, tx_lo_in};
   wire [31:0] ratio_pair = {rx_ratio_bits, tx_ratio_bits};
   reg  [1:0]  main_o_q;
   reg  [1:0]  main_oe_q;
   reg  [1:0]  aux_o_q;
   reg  [1:0]  aux_oe_q;
   reg  [1:0]  unl_oe_q;
   reg  [1:0]  fl_q;

   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_loop
         reg  [2:0]  lo_sync_q;
         reg  [16:0] lo_cnt_q;
         reg         div_tick_q;
         reg         lead_q;
         reg         lag_q;
         reg  [9:0]  err_q;
         reg  [19:0] hold_q;
         reg  [19:0] hold_d;
         wire        lo_edge = lo_sync_q[1] & ~lo_sync_q[2];
         wire [16:0] div_n = {ratio_pair[16*i +: 16], 1'b0};
         wire        pulse = lead_q | lag_q;
         wire        exceed = pulse & (err_q >= thr_cyc);
         wire        drive = pulse & (err_q >= dz_cyc);

         // oscillator divider, ratio is twice the setting
         always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               lo_sync_q  <= 3'h0;
               lo_cnt_q   <= 17'h00000;
               div_tick_q <= 1'b0;
            end else begin
               lo_sync_q  <= {lo_sync_q[1:0], lo_pin[i]};
               div_tick_q <= 1'b0;
               if (lo_edge) begin
                  if (lo_cnt_q >= div_n - 17'h00001) begin // RULE_04
                     lo_cnt_q   <= 17'h00000;
                     div_tick_q <= cfg_valid_q;
                  end else begin
                     lo_cnt_q <= lo_cnt_q + 17'h00001;
                  end
               end
            end
         end

         // tri-state phase-frequency detector; simultaneous edges leave its state unchanged
         always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               lead_q <= 1'b0;
               lag_q  <= 1'b0;
               err_q  <= 10'h000;
            end else begin
               if (div_tick_q && !ref_tick_q) begin
                  if (lag_q)
                     lag_q <= 1'b0;
                  else
                     lead_q <= 1'b1; // RULE_05
               end else if (ref_tick_q && !div_tick_q) begin
                  if (lead_q)
                     lead_q <= 1'b0;
                  else
                     lag_q <= 1'b1; // RULE_05
               end
               if (!pulse)
                  err_q <= 10'h000;
               else if (err_q != 10'h3FF)
                  err_q <= err_q + 10'h001;
            end
         end

         // extension counter reloads every cycle the error is at or over the limit
         always @* begin
            hold_d = hold_q;
            if (exceed)
               hold_d = hold_len; // RULE_08
            else if (hold_q != 20'h00000)
               hold_d = hold_q - 20'h00001;
         end

         always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               hold_q       <= 20'h00000;
               main_o_q[i]  <= 1'b0;
               main_oe_q[i] <= 1'b0;
               aux_o_q[i]   <= 1'b0;
               aux_oe_q[i]  <= 1'b0;
               unl_oe_q[i]  <= 1'b0;
               fl_q[i]      <= 1'b0;
            end else begin
               hold_q       <= hold_d;
               main_o_q[i]  <= lead_q; // RULE_05
               main_oe_q[i] <= drive; // RULE_06
               aux_o_q[i]   <= lead_q; // RULE_07
               aux_oe_q[i]  <= drive & (hold_d != 20'h00000); // RULE_16
               unl_oe_q[i]  <= (hold_d != 20'h00000); // RULE_07 RULE_18
               fl_q[i]      <= cfg_valid_q & fast_lock_en[i] // RULE_13
                               & (fast_lock_policy | (hold_d != 20'h00000)); // RULE_14
            end
         end
      end
   endgenerate

   // ****************************************************************
   // output pins
   // ****************************************************************
   // open-drain level register never leaves zero; only the enable moves
   reg unl_level_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         unl_level_q <= 1'b0;
      else
         unl_level_q <= 1'b0;
   end

   assign tx_pump_main_out   = main_o_q[0];
   assign tx_pump_main_oe    = main_oe_q[0];
   assign rx_pump_main_out   = main_o_q[1];
   assign rx_pump_main_oe    = main_oe_q[1];
   assign tx_pump_aux_out    = aux_o_q[0];
   assign tx_pump_aux_oe     = aux_oe_q[0];
   assign rx_pump_aux_out    = aux_o_q[1];
   assign rx_pump_aux_oe     = aux_oe_q[1];
   assign tx_unlock_n        = unl_level_q;
   assign tx_unlock_oe       = unl_oe_q[0];
   assign rx_unlock_n        = unl_level_q;
   assign rx_unlock_oe       = unl_oe_q[1];
   assign tx_fast_lock_on    = fl_q[0];
   assign rx_fast_lock_on    = fl_q[1];
   assign factory_test_bit_a = cfg_q[`DPS_TEST_A_BIT];
   assign factory_test_bit_b = cfg_q[`DPS_TEST_B_BIT];
   assign cfg_loaded         = cfg_valid_q;

endmodule
`default_nettype wire

/* File: sim/dps_core_assertions.sv */
// port-level concurrent checks for the dual synthesizer core
`timescale 1ns/1ps
`default_nettype none
module dps_core_assertions (
   input wire logic clk,                 // system clock
   input wire logic arst_n,              // async reset, active low
   input wire logic serial_enable,       // frame enable pin
   input wire logic tx_pump_main_out,    // tx main level
   input wire logic tx_pump_main_oe,     // tx main enable
   input wire logic rx_pump_main_out,    // rx main level
   input wire logic rx_pump_main_oe,     // rx main enable
   input wire logic tx_pump_aux_out,     // tx aux level
   input wire logic tx_pump_aux_oe,      // tx aux enable
   input wire logic rx_pump_aux_out,     // rx aux level
   input wire logic rx_pump_aux_oe,      // rx aux enable
   input wire logic tx_unlock_n,         // tx unlock level
   input wire logic tx_unlock_oe,        // tx unlock pull-down
   input wire logic rx_unlock_n,         // rx unlock level
   input wire logic rx_unlock_oe,        // rx unlock pull-down
   input wire logic tx_fast_lock_on,     // tx fast-lock switch
   input wire logic factory_test_bit_a,  // stored test bit a
   input wire logic factory_test_bit_b,  // stored test bit b
   input wire logic cfg_loaded           // word taken
);
   // ****************************************************************
   // cycles since the last frame ended, saturating at 7
   // ****************************************************************
   logic       en_q;
   logic [2:0] end_cnt_q;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         en_q      <= 1'h0;
         end_cnt_q <= 3'h7;
      end else begin
         en_q <= serial_enable;
         if (en_q && !serial_enable)
            end_cnt_q <= 3'h0;
         else if (end_cnt_q != 3'h7)
            end_cnt_q <= end_cnt_q + 3'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_frame_end;
      end_cnt_q >= 3'h2 && end_cnt_q <= 3'h6;
   endsequence
   sequence s_tx_unlock_soon;
      ##[0:2] tx_unlock_oe;
   endsequence
   AST_UNLOCK_N_LOW: assert property (!tx_unlock_n && !rx_unlock_n)
      else $error("unlock pin level not low");
   AST_TX_AUX_COPY: assert property (tx_pump_aux_oe |-> tx_pump_aux_out == tx_pump_main_out)
      else $error("tx aux level differs from main");
   AST_RX_AUX_COPY: assert property (rx_pump_aux_oe |-> rx_pump_aux_out == rx_pump_main_out)
      else $error("rx aux level differs from main");
   AST_TX_AUX_UNLOCKED: assert property (tx_pump_aux_oe |-> s_tx_unlock_soon)
      else $error("tx aux driving while locked");
   AST_RX_AUX_UNLOCKED: assert property (rx_pump_aux_oe |-> ##[0:2] rx_unlock_oe)
      else $error("rx aux driving while locked");
   AST_QUIET_BEFORE_CFG: assert property (!cfg_loaded |-> !(tx_pump_main_oe || rx_pump_main_oe ||
      tx_pump_aux_oe || rx_pump_aux_oe || tx_unlock_oe || rx_unlock_oe))
      else $error("pin driven before a word was loaded");
   AST_CFG_STICKY: assert property (cfg_loaded |=> cfg_loaded)
      else $error("loaded flag dropped");
   AST_CFG_AFTER_FRAME: assert property (($rose(cfg_loaded) || $changed(factory_test_bit_a) ||
      $changed(factory_test_bit_b)) |-> s_frame_end)
      else $error("settings changed away from a frame end");
   AST_TX_FL_CAUSE: assert property ($rose(tx_fast_lock_on) |-> (s_frame_end or s_tx_unlock_soon))
      else $error("tx fast-lock rose without cause");
endmodule
bind dps_core dps_core_assertions dps_core_assertions_inst (
   .clk(clk), .arst_n(arst_n), .serial_enable(serial_enable),
   .tx_pump_main_out(tx_pump_main_out), .tx_pump_main_oe(tx_pump_main_oe),
   .rx_pump_main_out(rx_pump_main_out), .rx_pump_main_oe(rx_pump_main_oe),
   .tx_pump_aux_out(tx_pump_aux_out), .tx_pump_aux_oe(tx_pump_aux_oe),
   .rx_pump_aux_out(rx_pump_aux_out), .rx_pump_aux_oe(rx_pump_aux_oe),
   .tx_unlock_n(tx_unlock_n), .tx_unlock_oe(tx_unlock_oe), .rx_unlock_n(rx_unlock_n),
   .rx_unlock_oe(rx_unlock_oe), .tx_fast_lock_on(tx_fast_lock_on),
   .factory_test_bit_a(factory_test_bit_a), .factory_test_bit_b(factory_test_bit_b),
   .cfg_loaded(cfg_loaded));
`default_nettype wire

/* File: sim/dps_host_model.sv */
// host side of the three-wire serial bus
`timescale 1ns/1ps
`default_nettype none
module dps_host_model #(
   parameter int GAP = 132  // clk cycles per bus interval
) (
   input  wire logic clk,                  // system clock
   output var  logic serial_in_line,       // data line
   output var  logic serial_shift_strobe,  // shift clock
   output var  logic serial_enable         // frame enable
);
   initial begin
      serial_in_line      = 1'h0;
      serial_shift_strobe = 1'h0;
      serial_enable       = 1'h0;
   end
   // interval kept above 32 periods of the bench's 32 ns reference
   task automatic pause();
      repeat (GAP) @(posedge clk);
   endtask
   task automatic send(input logic [47:0] word, input int nbits);
      int i;
      serial_enable <= 1'h1;
      pause();
      for (i = 0; i < nbits; i++) begin
         serial_in_line <= word[i];
         pause();
         serial_shift_strobe <= 1'h1;
         pause();
         serial_shift_strobe <= 1'h0;
      end
      pause();
      serial_enable <= 1'h0;
      // released line has no pull, so show a changed level
      serial_in_line <= ~serial_in_line;
      pause();
   endtask
endmodule
`default_nettype wire

/* File: sim/test_dual_pll_divider_lock_detect.sv */
// self-checking bench for the dual synthesizer core
`timescale 1ns/1ps
`default_nettype none
module test_dual_pll_divider_lock_detect;
   logic clk = 1'h0, arst_n = 1'h0, run = 1'h0;
   logic ref_osc_in = 1'h0, tx_lo_in = 1'h0, rx_lo_in = 1'h0;
   wire  serial_in_line, serial_shift_strobe, serial_enable;
   wire  tx_pump_main_out, tx_pump_main_oe, rx_pump_main_out, rx_pump_main_oe;
   wire  tx_pump_aux_out, tx_pump_aux_oe, rx_pump_aux_out, rx_pump_aux_oe;
   wire  tx_unlock_n, tx_unlock_oe, rx_unlock_n, rx_unlock_oe;
   wire  tx_fast_lock_on, rx_fast_lock_on, factory_test_bit_a, factory_test_bit_b, cfg_loaded;
   int   total_checks = 0, miscompares = 0, tick_q = 0, elapsed = 0;
   logic [47:0] w1, w2;
   always #4 clk = ~clk;
   // ****************************************************************
   // oscillators: reference period 4 clk, local oscillators 6 clk
   // ****************************************************************
   always @(posedge clk) begin
      tick_q     <= run ? tick_q + 1 : 0;
      elapsed    <= run ? elapsed + 1 : 0;
      ref_osc_in <= run && ((tick_q / 2) % 2 == 1);
      tx_lo_in   <= run && ((tick_q / 3) % 2 == 1);
      rx_lo_in   <= run && ((tick_q / 3) % 2 == 1);
   end
   dps_core #(.HOLD_SHORT_CYC(50), .HOLD_LONG_CYC(100)) dps_core_inst (
      .clk(clk), .arst_n(arst_n), .ref_osc_in(ref_osc_in), .tx_lo_in(tx_lo_in), .rx_lo_in(rx_lo_in),
      .serial_in_line(serial_in_line), .serial_shift_strobe(serial_shift_strobe),
      .serial_enable(serial_enable), .tx_pump_main_out(tx_pump_main_out),
      .tx_pump_main_oe(tx_pump_main_oe), .rx_pump_main_out(rx_pump_main_out),
      .rx_pump_main_oe(rx_pump_main_oe), .tx_pump_aux_out(tx_pump_aux_out),
      .tx_pump_aux_oe(tx_pump_aux_oe), .rx_pump_aux_out(rx_pump_aux_out),
      .rx_pump_aux_oe(rx_pump_aux_oe), .tx_unlock_n(tx_unlock_n), .tx_unlock_oe(tx_unlock_oe),
      .rx_unlock_n(rx_unlock_n), .rx_unlock_oe(rx_unlock_oe), .tx_fast_lock_on(tx_fast_lock_on),
      .rx_fast_lock_on(rx_fast_lock_on), .factory_test_bit_a(factory_test_bit_a),
      .factory_test_bit_b(factory_test_bit_b), .cfg_loaded(cfg_loaded));
   dps_host_model #(.GAP(132)) dps_host_model_inst (
      .clk(clk), .serial_in_line(serial_in_line), .serial_shift_strobe(serial_shift_strobe),
      .serial_enable(serial_enable));
   // ****************************************************************
   // checking helpers
   // ****************************************************************
   task automatic chk(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      total_checks++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   function automatic logic pick(input int w);
      case (w)
         0: return tx_pump_main_oe;
         1: return rx_pump_main_oe;
         default: return cfg_loaded;
      endcase
   endfunction
   // bounded wait, then the level itself is checked
   task automatic wait_for(input string what, input int w, input logic lvl, input int lim);
      int n;
      n = 0;
      while (pick(w) !== lvl && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(what, lvl, pick(w));
   endtask
   task automatic stop_test();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge clk);
      miscompares++;
      stop_test();
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      // test bits, policy, rx en, tx en, dz hi/lo, hold, threshold, ref code, rx, tx
      w1 = {1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 3'h0, 5'h00, 16'h0400, 16'h0100};
      w2 = w1;
      w2[45] = 1'h0;
      w2[40:37] = 4'h9;
      repeat (2) @(posedge clk);
      arst_n <= 1'h1;
      @(posedge clk);
      #1;
      chk("cfg_loaded", 1'h0, cfg_loaded);
      chk("tx_unlock_oe", 1'h0, tx_unlock_oe);
      @(posedge clk);
      dps_host_model_inst.send(w1, 47);
      repeat (10) @(posedge clk);
      #1;
      chk("cfg_loaded short frame", 1'h0, cfg_loaded);
      @(posedge clk);
      dps_host_model_inst.send(w1, 48);
      wait_for("cfg_loaded", 2, 1'h1, 20);
      chk("tx_fast_lock_on", 1'h1, tx_fast_lock_on);
      chk("rx_fast_lock_on", 1'h0, rx_fast_lock_on);
      chk("test bits and unlock levels", 1'h0, factory_test_bit_a | factory_test_bit_b | tx_unlock_n | rx_unlock_n);
      @(posedge clk);
      dps_host_model_inst.send(w2, 48);
      repeat (20) @(posedge clk);
      #1;
      chk("tx_fast_lock_on locked", 1'h0, tx_fast_lock_on);
      @(posedge clk);
      run <= 1'h1;
      wait_for("tx_pump_main_oe", 0, 1'h1, 4000);
      chk_rng("tx lead delay", 3069, 3081, elapsed);
      chk("tx_pump_main_out", 1'h1, tx_pump_main_out);
      repeat (3) @(posedge clk);
      #1;
      chk("tx_unlock_oe below threshold", 1'h0, tx_unlock_oe);
      repeat (17) @(posedge clk);
      #1;
      chk("tx_pump_aux_oe", 1'h1, tx_pump_aux_oe);
      chk("tx_pump_aux_out", 1'h1, tx_pump_aux_out);
      chk("tx_unlock_oe", 1'h1, tx_unlock_oe);
      chk("tx_fast_lock_on unlocked", 1'h1, tx_fast_lock_on);
      wait_for("rx_pump_main_oe", 1, 1'h1, 6000);
      chk_rng("rx lag delay", 8190, 8202, elapsed);
      chk("rx_pump_main_out", 1'h0, rx_pump_main_out);
      chk("rx_fast_lock_on", 1'h0, rx_fast_lock_on);
      wait_for("rx_pump_main_oe end", 1, 1'h0, 5000);
      repeat (4) @(posedge clk);
      #1;
      chk("rx_unlock_oe held", 1'h1, rx_unlock_oe);
      chk("rx_pump_aux_oe", 1'h0, rx_pump_aux_oe);
      repeat (90) @(posedge clk);
      #1;
      chk("rx_unlock_oe late", 1'h1, rx_unlock_oe);
      repeat (10) @(posedge clk);
      #1;
      chk("rx_unlock_oe released", 1'h0, rx_unlock_oe);
      stop_test();
   end
endmodule
`default_nettype wire
